// [pbp_board.sv]
// Purpose: Board circuitry on the port pins.
// Assumes: No pull resistors; undriven pins float to a changing level.
// Notes: ext is refreshed by the bench every cycle.
`timescale 1ns/100ps
module pbp_board (
    // Pin side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] ext,
    output logic [7:0] pin_in
);
    // Driven pins read their drive, released pins the board level
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule : pbp_board

// [pbp_monitor.sv]
// Purpose: Port checks on the low pin selector.
// Assumes: Outputs are combinational from inputs and two registers.
// Notes: Direction register effects are seen through the upper pin output enables.
`timescale 1ns/100ps
module pbp_monitor
    import pbp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register side
    input wire logic hw_standby,
    input wire logic dir_wr,
    input wire logic [7:0] dir_wdata,
    input wire logic [7:0] dir_rdata,
    input wire logic [7:0] data_rdata,
    // Selects
    input wire pbp_timer_cfg_t timer_cfg_0,
    input wire pbp_timer_cfg_t timer_cfg_1,
    input wire pbp_timer_cfg_t timer_cfg_2,
    input wire logic chip_select_5_enable,
    input wire logic chip_select_6_enable,
    // Pins and capture
    input wire logic timer1_capture_in,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_oe_n,
    input wire pbp_src_t [2:0] pin_src
);
    // Timer claim of each channel
    wire tc0 = |timer_cfg_0[4:1];
    wire tc1 = |timer_cfg_1[4:1];
    wire tc2 = |timer_cfg_2[4:1];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_rd; dir_rdata == PBP_DIR_READ; endproperty
    a_rd: assert property (p_rd) else $error("dir readback wrong");
    property p_t2; tc2 |-> pin_src[2] == PBP_SRC_TIMER; endproperty
    a_t2: assert property (p_t2) else $error("pin2 timer");
    property p_c5; !tc2 && chip_select_5_enable |-> pin_src[2] == PBP_SRC_CHIPSEL; endproperty
    a_c5: assert property (p_c5) else $error("pin2 cs");
    property p_c6; !tc1 && chip_select_6_enable |-> pin_src[1] == PBP_SRC_CHIPSEL; endproperty
    a_c6: assert property (p_c6) else $error("pin1 cs");
    property p_t0; tc0 |-> pin_src[0] == PBP_SRC_TIMER; endproperty
    a_t0: assert property (p_t0) else $error("pin0 timer");
    property p_cap; timer_cfg_1[0] |-> timer1_capture_in == pin_in[1]; endproperty
    a_cap: assert property (p_cap) else $error("capture path");
    property p_hs; hw_standby |=> pin_oe_n[7:3] == 5'h1F; endproperty
    a_hs: assert property (p_hs) else $error("standby clear");
    property p_wr; dir_wr && !hw_standby |=> pin_oe_n[7:3] == ~$past(dir_wdata[7:3]); endproperty
    a_wr: assert property (p_wr) else $error("dir write");
    property p_in; pin_oe_n[7] |-> data_rdata[7] == pin_in[7]; endproperty
    a_in: assert property (p_in) else $error("port read");
endmodule : pbp_monitor
bind pbp_port_b_low_mux pbp_monitor i_mon (.*);

// [pbp_pkg.sv]
// Purpose: Shared types and constants for the port pin function selector.
// Assumes: Single 100 MHz clock domain, no register bus.
// Notes: Field layouts of the control inputs travel as packed structs.
package pbp_pkg;
    localparam int PBP_PINS = 3;
    localparam logic [7:0] PBP_DIR_RESET = 8'h00;
    localparam logic [7:0] PBP_DATA_RESET = 8'h00;
    localparam logic [7:0] PBP_DIR_READ = 8'hFF;
    localparam logic [1:0] PBP_SEL_OFF = 2'h0;

    // Output-select and capture-enable fields of one 8-bit timer channel
    typedef struct packed {
        logic [1:0] out_sel_high;
        logic [1:0] out_sel_low;
        logic capture_enable;
    } pbp_timer_cfg_t;

    // Driver source chosen for a pin
    typedef enum logic [2:0] {
        PBP_SRC_INPUT = 3'h0,
        PBP_SRC_PORT = 3'h1,
        PBP_SRC_PATTERN = 3'h3,
        PBP_SRC_CHIPSEL = 3'h2,
        PBP_SRC_TIMER = 3'h6
    } pbp_src_t;
endpackage : pbp_pkg

// [pbp_port_b_low_mux.sv]
// Purpose: Pin function selection for the three low pins of the 8-bit port.
// Assumes: Inputs synchronous to ref_clk; standby flags are levels.
// Assumes: Software standby needs no input; the registers simply hold.
// Notes: Pins are split into in, out and active-low output enable.
// Notes: Each low pin picks timer, then chip select, then direction and pattern.
// Notes: Upper pins 7 to 3 are plain port bits.
`timescale 1ns/100ps
module pbp_port_b_low_mux
    import pbp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Standby mode
    input wire logic hw_standby,
    // Register writes from the CPU side
    input wire logic dir_wr,
    input wire logic [7:0] dir_wdata,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    // Register reads
    output logic [7:0] dir_rdata,
    output logic [7:0] data_rdata,
    // Peripheral selects
    input wire pbp_timer_cfg_t timer_cfg_0,
    input wire pbp_timer_cfg_t timer_cfg_1,
    input wire pbp_timer_cfg_t timer_cfg_2,
    // Clear field, chip select and pattern enables
    input wire logic [1:0] counter_clear_select,
    input wire logic chip_select_5_enable,
    input wire logic chip_select_6_enable,
    input wire logic chip_select_7_enable,
    input wire logic [2:0] pattern_enable_high_group,
    // Peripheral signals
    input wire logic timer8_ch0_out,
    input wire logic timer8_ch1_io,
    input wire logic timer8_ch2_out,
    input wire logic pattern_out_8,
    input wire logic pattern_out_9,
    input wire logic pattern_out_10,
    input wire logic chip_select_5_n,
    input wire logic chip_select_6_n,
    input wire logic chip_select_7_n,
    // Capture path to timer channel 1
    output logic timer1_capture_in,
    output logic capture_enable_1,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output pbp_src_t [2:0] pin_src
);
    // Port registers and their next values
    logic [7:0] port_direction_reg;
    logic [7:0] port_direction_next;
    logic [7:0] port_output_data_reg;
    logic [7:0] port_output_data_next;

    // Write strobes that hardware standby has not blocked
    logic dir_write_taken;
    logic data_write_taken;

    // Timer claim of each channel
    logic tmr2_on;
    logic tmr1_on;
    logic tmr0_on;

    // Per-pin selects, bit n belongs to low pin n
    logic [2:0] timer_claim;
    logic [2:0] chip_select_claim;
    logic [2:0] low_direction;
    logic [2:0] pattern_claim;

    // Per-pin levels offered by each source
    logic [2:0] timer_level;
    logic [2:0] chip_select_level;
    logic [2:0] pattern_level;
    logic [2:0] port_level;

    // Low pins that are left as inputs
    logic [2:0] low_pin_input;

    // Timer output is live when any select bit is non-zero
    function automatic logic timer_on(
        input pbp_timer_cfg_t c
    );
        timer_on = (c.out_sel_high != PBP_SEL_OFF) || (c.out_sel_low != PBP_SEL_OFF);
    endfunction : timer_on

    // Priority: timer, chip select, then direction and pattern enable
    function automatic pbp_src_t pick(
        input logic tmr,
        input logic cs,
        input logic dir,
        input logic pat
    );
        if (tmr) begin
            pick = PBP_SRC_TIMER;
        end else if (cs) begin
            pick = PBP_SRC_CHIPSEL;
        end else if (!dir) begin
            pick = PBP_SRC_INPUT;
        end else if (pat) begin
            pick = PBP_SRC_PATTERN; // Pattern output needs the direction bit as well
        end else begin
            pick = PBP_SRC_PORT;
        end
    endfunction : pick

    // Drive value for a chosen source; an input pin is not driven
    function automatic logic drive(
        input pbp_src_t s,
        input logic tmr,
        input logic cs,
        input logic pat,
        input logic dat
    );
        case (s)
            PBP_SRC_TIMER: drive = tmr;
            PBP_SRC_CHIPSEL: drive = cs;
            PBP_SRC_PATTERN: drive = pat;
            PBP_SRC_PORT: drive = dat;
            default: drive = 1'b0;
        endcase
    endfunction : drive

    // Channel claims; the channel 1 clear field is accepted but never vetoes the claim
    assign tmr2_on = timer_on(timer_cfg_2);
    assign tmr1_on = timer_on(timer_cfg_1)
                     && (counter_clear_select != PBP_SEL_OFF || 1'b1);
    assign tmr0_on = timer_on(timer_cfg_0);

    // Selects per pin: pin 2 uses chip select 5, pin 1 uses 6, pin 0 uses 7
    assign timer_claim = {tmr2_on, tmr1_on, tmr0_on};
    assign chip_select_claim = {chip_select_5_enable, chip_select_6_enable,
                                chip_select_7_enable};
    assign low_direction = port_direction_reg[2:0];
    assign pattern_claim = pattern_enable_high_group; // Pattern enables 10, 9, 8

    // Levels offered by timer, chip select, pattern and port data
    assign timer_level = {timer8_ch2_out, timer8_ch1_io, timer8_ch0_out};
    assign chip_select_level = {chip_select_5_n, chip_select_6_n, chip_select_7_n};
    assign pattern_level = {pattern_out_10, pattern_out_9, pattern_out_8};
    assign port_level = port_output_data_reg[2:0];

    // Source selection per pin
    assign pin_src[2] = pick(timer_claim[2], chip_select_claim[2], low_direction[2],
                             pattern_claim[2]);
    assign pin_src[1] = pick(timer_claim[1], chip_select_claim[1], low_direction[1],
                             pattern_claim[1]);
    assign pin_src[0] = pick(timer_claim[0], chip_select_claim[0], low_direction[0],
                             pattern_claim[0]);

    // Pin drive values of the low pins
    assign pin_out[2] = drive(pin_src[2], timer_level[2], chip_select_level[2],
                              pattern_level[2], port_level[2]);
    assign pin_out[1] = drive(pin_src[1], timer_level[1], chip_select_level[1],
                              pattern_level[1], port_level[1]);
    assign pin_out[0] = drive(pin_src[0], timer_level[0], chip_select_level[0],
                              pattern_level[0], port_level[0]);

    // Output enable is low while driving; a timer or chip select claimed pin always drives
    assign low_pin_input[2] = (pin_src[2] == PBP_SRC_INPUT);
    assign low_pin_input[1] = (pin_src[1] == PBP_SRC_INPUT);
    assign low_pin_input[0] = (pin_src[0] == PBP_SRC_INPUT);
    assign pin_oe_n[2:0] = low_pin_input;

    // Upper pins 7 to 3 are plain port bits
    assign pin_out[7:3] = port_output_data_reg[7:3];
    assign pin_oe_n[7:3] = ~port_direction_reg[7:3];

    // Capture enable copied out for the timer
    assign capture_enable_1 = timer_cfg_1.capture_enable;

    // Capture input is the pin level gated by capture enable, whatever the pin direction is
    assign timer1_capture_in = timer_cfg_1.capture_enable & pin_in[1];

    // Direction register cannot be read back
    assign dir_rdata = PBP_DIR_READ;

    // Port read: stored bit on outputs, pin level on inputs
    assign data_rdata = (port_direction_reg & port_output_data_reg)
                      | (~port_direction_reg & pin_in);

    // Hardware standby wins over a write in the same cycle
    assign dir_write_taken = dir_wr && !hw_standby;
    assign data_write_taken = data_wr && !hw_standby;

    // Next values; hardware standby clears, software standby needs nothing here
    assign port_direction_next = hw_standby ? PBP_DIR_RESET
                               : dir_write_taken ? dir_wdata
                               : port_direction_reg;
    assign port_output_data_next = hw_standby ? PBP_DATA_RESET
                                 : data_write_taken ? data_wdata
                                 : port_output_data_reg;

    // Direction register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_direction_reg <= PBP_DIR_RESET;
        end else begin
            port_direction_reg <= port_direction_next;
        end
    end

    // Output data register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_output_data_reg <= PBP_DATA_RESET;
        end else begin
            port_output_data_reg <= port_output_data_next;
        end
    end
endmodule : pbp_port_b_low_mux

// [testbench.sv]
// Purpose: Random self-checking bench for the low pin selector.
// Assumes: Model registers follow reset, standby and write strobes.
// Notes: Mid-run reset at cycle 1000.
`timescale 1ns/100ps
module testbench;
    import pbp_pkg::*;
    logic ref_clk, nrst, hw_standby, dir_wr, data_wr, chip_select_5_enable, chip_select_6_enable;
    logic chip_select_7_enable, timer8_ch0_out, timer8_ch1_io, timer8_ch2_out, pattern_out_8;
    logic pattern_out_9, pattern_out_10, chip_select_5_n, chip_select_6_n, chip_select_7_n;
    logic timer1_capture_in, capture_enable_1;
    logic [7:0] dir_wdata, data_wdata, dir_rdata, data_rdata, pin_in, pin_out, pin_oe_n, ext;
    logic [7:0] mdir = 0, mdat = 0, eo, ev, ep;
    logic [1:0] counter_clear_select;
    logic [2:0] pattern_enable_high_group, t, c, vt, vc, vp;
    logic [95:0] r;
    pbp_timer_cfg_t timer_cfg_0, timer_cfg_1, timer_cfg_2;
    pbp_src_t [2:0] pin_src;
    pbp_src_t es;
    int n_errors = 0, cmp_count = 0, seed = 32'haa47;
    pbp_port_b_low_mux i_pbp_port_b_low_mux (.*);
    pbp_board i_pbp_board (.*);
    // Clock
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Random drive of every input, claims and standby thinned out
    task automatic drv(input int k);
        r = {$random(seed), $random(seed), $random(seed)};
        nrst = (k % 1000) > 2;
        {hw_standby, dir_wr, data_wr, chip_select_5_enable, chip_select_6_enable,
            chip_select_7_enable, timer8_ch0_out, timer8_ch1_io, timer8_ch2_out, pattern_out_8,
            pattern_out_9, pattern_out_10, chip_select_5_n, chip_select_6_n, chip_select_7_n,
            dir_wdata, data_wdata, ext, timer_cfg_0, timer_cfg_1, timer_cfg_2,
            counter_clear_select, pattern_enable_high_group} = r[58:0];
        hw_standby = r[95:92] == 4'h0;
        if (r[91]) {timer_cfg_0[4:1], timer_cfg_1[4:1], timer_cfg_2[4:1]} = 12'h000;
        if (r[90]) {chip_select_5_enable, chip_select_6_enable, chip_select_7_enable} = 3'h0;
    endtask : drv
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Expected pins from the model registers
    task automatic check();
        t = {|timer_cfg_2[4:1], |timer_cfg_1[4:1], |timer_cfg_0[4:1]};
        c = {chip_select_5_enable, chip_select_6_enable, chip_select_7_enable};
        vt = {timer8_ch2_out, timer8_ch1_io, timer8_ch0_out};
        vc = {chip_select_5_n, chip_select_6_n, chip_select_7_n};
        vp = {pattern_out_10, pattern_out_9, pattern_out_8};
        eo = ~mdir;
        ev = mdat;
        for (int i = 0; i < 3; i++) begin
            es = t[i] ? PBP_SRC_TIMER : c[i] ? PBP_SRC_CHIPSEL : !mdir[i] ? PBP_SRC_INPUT :
                pattern_enable_high_group[i] ? PBP_SRC_PATTERN : PBP_SRC_PORT;
            eo[i] = es == PBP_SRC_INPUT;
            ev[i] = t[i] ? vt[i] : c[i] ? vc[i] : pattern_enable_high_group[i] ? vp[i] : mdat[i];
            chk({5'h00, pin_src[i]}, {5'h00, es});
        end
        chk(pin_oe_n, eo);
        chk(pin_out & ~eo, ev & ~eo);
        ep = (~eo & ev) | (eo & ext);
        chk(data_rdata, (mdir & mdat) | (~mdir & ep));
        chk(dir_rdata, 8'hFF);
        chk({7'h00, timer1_capture_in}, {7'h00, timer_cfg_1[0] & ep[1]});
        chk({7'h00, capture_enable_1}, {7'h00, timer_cfg_1[0]});
    endtask : check
    task automatic end_of_test();
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Main sequence: model update at each edge, compare mid-cycle
    initial begin
        drv(0);
        for (int k = 1; k < 2000; k++) begin
            @(posedge ref_clk);
            if (hw_standby) {mdir, mdat} = 16'h0000;
            else if (nrst) begin
                if (dir_wr) mdir = dir_wdata;
                if (data_wr) mdat = data_wdata;
            end
            #1 drv(k);
            if (!nrst) {mdir, mdat} = 16'h0000;
            @(negedge ref_clk) check();
        end
        end_of_test();
    end
endmodule : testbench
